/* File: core/ssb_pkg.sv */
package ssb_pkg;
   // ==========================================================
   // Geometry of the 512K x 36 configuration
   // ==========================================================
   localparam int ADDR_W = 19;
   localparam int LANE_W = 9;
   localparam int LANES = 4;
   localparam int DATA_W = LANE_W * LANES;
   // Every link pin passes through the synchroniser as one vector
   localparam int SYNC_W = 6 + LANES + ADDR_W + DATA_W;
   // Sync vector field positions (low bit of each field)
   localparam int POS_DATA = 0;
   localparam int POS_ADDR = DATA_W;
   localparam int POS_LANE = DATA_W + ADDR_W;
   localparam int POS_WR = POS_LANE + LANES;
   localparam int POS_RD = POS_WR + 1;
   localparam int POS_CN = POS_RD + 1;
   localparam int POS_C = POS_CN + 1;
   localparam int POS_KN = POS_C + 1;
   localparam int POS_K = POS_KN + 1;
   // Values after reset
   localparam logic [DATA_W-1:0] Q_RESET = 36'h0_0000_0000;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h0_0000;
   localparam logic [LANES-1:0] LANE_RESET = 4'hF;
   // Clock history starts high so no false rise follows reset
   localparam logic [3:0] CLK_RESET = 4'hF;
   localparam logic [SYNC_W-1:0] SYNC_RESET = '1;
   // Write port sequencing
   typedef enum logic {
      SSB_WR_IDLE,
      SSB_WR_ADDR
   } ssb_wr_e;
endpackage : ssb_pkg

/* File: core/ssb_sram.sv */
// How it works
// - Second beat of every burst uses the base address plus one.
// - Read select low at a master rise requests a read.
// - Write select low at a master rise requests a write.
// - Read and write sequencers run independently and may overlap.
// - All requests are taken on master positive clock rises.
// - Read beat0 leaves on output-negative rise, beat1 on output-positive.
// - Write beat0 taken at master rise, beat1 at master-negative rise.
// - Four active-low lane enables gate bytes; all high aborts the beat.
// - Write address is taken on the master-negative rise.
// - Reads of just-written addresses return the newest write data.
// - Output clocks both held high hand output timing to master pair.
// - A cycle without read select does not cut short a read burst.
`timescale 1ns/1ns
`default_nettype none
module ssb_sram (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic k_in,
   input wire logic k_n_in,
   input wire logic c_in,
   input wire logic c_n_in,
   input wire logic rd_sel_n_in,
   input wire logic wr_sel_n_in,
   input wire logic byte_lane0_wr_n_in,
   input wire logic byte_lane1_wr_n_in,
   input wire logic byte_lane2_wr_n_in,
   input wire logic byte_lane3_wr_n_in,
   input wire logic [ssb_pkg::ADDR_W-1:0] addr_in,
   input wire logic [ssb_pkg::DATA_W-1:0] data_in,
   output logic [ssb_pkg::DATA_W-1:0] q_out,
   output logic q_oe_out
);
   // ==========================================================
   // Link synchroniser and edge finder
   // ==========================================================
   logic [ssb_pkg::SYNC_W-1:0] s1_reg, s2_reg;
   logic [3:0] clk_d_reg, clk_s;
   logic k_rise, kn_rise, c_rise, cn_rise, c_tied;
   logic out_neg, out_pos, rd_n_s, wr_n_s;
   logic [ssb_pkg::LANES-1:0] lane_s;
   logic [ssb_pkg::ADDR_W-1:0] addr_s;
   logic [ssb_pkg::DATA_W-1:0] data_s;
   // Every pin is asynchronous to clock_in, so all take two flops
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         s1_reg <= ssb_pkg::SYNC_RESET;
         s2_reg <= ssb_pkg::SYNC_RESET;
         clk_d_reg <= ssb_pkg::CLK_RESET;
      end else begin
         s1_reg <= {k_in, k_n_in, c_in, c_n_in, rd_sel_n_in, wr_sel_n_in,
                    byte_lane3_wr_n_in, byte_lane2_wr_n_in,
                    byte_lane1_wr_n_in, byte_lane0_wr_n_in, addr_in,
                    data_in};
         s2_reg <= s1_reg;
         clk_d_reg <= clk_s;
      end
   end
   // Field extraction and edge detection look only at stage two
   always_comb begin
      clk_s = s2_reg[ssb_pkg::POS_K -: 4];
      rd_n_s = s2_reg[ssb_pkg::POS_RD];
      wr_n_s = s2_reg[ssb_pkg::POS_WR];
      lane_s = s2_reg[ssb_pkg::POS_LANE +: ssb_pkg::LANES];
      addr_s = s2_reg[ssb_pkg::POS_ADDR +: ssb_pkg::ADDR_W];
      data_s = s2_reg[ssb_pkg::POS_DATA +: ssb_pkg::DATA_W];
      k_rise = clk_s[3] & ~clk_d_reg[3];
      kn_rise = clk_s[2] & ~clk_d_reg[2];
      c_rise = clk_s[1] & ~clk_d_reg[1];
      cn_rise = clk_s[0] & ~clk_d_reg[0];
      c_tied = clk_s[1] & clk_s[0] & clk_d_reg[1] & clk_d_reg[0];
      out_neg = c_tied ? kn_rise : cn_rise;
      out_pos = c_tied ? k_rise : c_rise;
   end
   // ==========================================================
   // Storage array and byte-lane merge
   // ==========================================================
   logic [ssb_pkg::DATA_W-1:0] mem [0:(1 << ssb_pkg::ADDR_W)-1];
   function automatic logic [ssb_pkg::DATA_W-1:0] lane_merge(
      input logic [ssb_pkg::DATA_W-1:0] old_w,
      input logic [ssb_pkg::DATA_W-1:0] new_w,
      input logic [ssb_pkg::LANES-1:0] lane_n);
      logic [ssb_pkg::DATA_W-1:0] res;
      res = old_w;
      // A high lane keeps its old byte; all high leaves word untouched
      for (int i = 0; i < ssb_pkg::LANES; i++) begin
         if (!lane_n[i]) begin
            res[i*ssb_pkg::LANE_W +: ssb_pkg::LANE_W] =
               new_w[i*ssb_pkg::LANE_W +: ssb_pkg::LANE_W];
         end
      end
      return res;
   endfunction : lane_merge
   // ==========================================================
   // Write sequencer
   // ==========================================================
   ssb_pkg::ssb_wr_e wr_state_reg, wr_state_next;
   logic [ssb_pkg::DATA_W-1:0] wd0_reg, wd0_next, wr_word0, wr_word1;
   logic [ssb_pkg::LANES-1:0] wl0_reg, wl0_next;
   logic wr_commit;
   logic [ssb_pkg::ADDR_W-1:0] wa0, wa1;
   // Beat 0 waits in a holding register until the address arrives
   always_comb begin
      wr_state_next = wr_state_reg;
      wd0_next = wd0_reg;
      wl0_next = wl0_reg;
      wr_commit = 1'b0;
      wa0 = addr_s;
      wa1 = ssb_pkg::ADDR_W'(addr_s + 1'b1);
      wr_word0 = lane_merge(mem[wa0], wd0_reg, wl0_reg);
      wr_word1 = lane_merge(mem[wa1], data_s, lane_s);
      case (wr_state_reg)
         ssb_pkg::SSB_WR_IDLE: begin
            if (k_rise && !wr_n_s) begin
               wd0_next = data_s;
               wl0_next = lane_s;
               wr_state_next = ssb_pkg::SSB_WR_ADDR;
            end
         end
         ssb_pkg::SSB_WR_ADDR: begin
            if (kn_rise) begin
               wr_commit = 1'b1;
               wr_state_next = ssb_pkg::SSB_WR_IDLE;
            end
         end
         default: wr_state_next = ssb_pkg::SSB_WR_IDLE;
      endcase
   end
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         wr_state_reg <= ssb_pkg::SSB_WR_IDLE;
         wd0_reg <= ssb_pkg::Q_RESET;
         wl0_reg <= ssb_pkg::LANE_RESET;
      end else begin
         wr_state_reg <= wr_state_next;
         wd0_reg <= wd0_next;
         wl0_reg <= wl0_next;
      end
   end
   // Array update; contents are undefined until first written
   always_ff @(posedge clock_in) begin
      if (wr_commit) begin
         mem[wa0] <= wr_word0;
         mem[wa1] <= wr_word1;
      end
   end
   // ==========================================================
   // Read sequencer and output pipeline
   // ==========================================================
   logic ra_vld_reg, ra_vld_next, rb_vld_reg, rb_vld_next;
   logic rt_vld_reg, rt_vld_next, q_oe_next;
   logic [ssb_pkg::ADDR_W-1:0] ra_addr_reg, ra_addr_next;
   logic [ssb_pkg::ADDR_W-1:0] rb_addr_reg, rb_addr_next;
   logic [ssb_pkg::ADDR_W-1:0] rt_addr_reg, rt_addr_next;
   logic [ssb_pkg::DATA_W-1:0] q_next;
   // Bypass: a write landing this cycle beats the stale array word
   function automatic logic [ssb_pkg::DATA_W-1:0] fetch(
      input logic [ssb_pkg::ADDR_W-1:0] a,
      input logic [ssb_pkg::DATA_W-1:0] arr_w,
      input logic commit,
      input logic [ssb_pkg::ADDR_W-1:0] a0,
      input logic [ssb_pkg::ADDR_W-1:0] a1,
      input logic [ssb_pkg::DATA_W-1:0] w0,
      input logic [ssb_pkg::DATA_W-1:0] w1);
      return (commit && a == a1) ? w1 :
             ((commit && a == a0) ? w0 : arr_w);
   endfunction : fetch
   // Stage A holds a fresh read, B waits for the output slot, T is beat 1
   always_comb begin
      ra_vld_next = ra_vld_reg;
      ra_addr_next = ra_addr_reg;
      rb_vld_next = rb_vld_reg;
      rb_addr_next = rb_addr_reg;
      rt_vld_next = rt_vld_reg;
      rt_addr_next = rt_addr_reg;
      q_next = q_out;
      q_oe_next = q_oe_out;
      if (out_neg) begin
         q_oe_next = rb_vld_reg;
         if (rb_vld_reg) begin
            q_next = fetch(rb_addr_reg, mem[rb_addr_reg], wr_commit, wa0,
                           wa1, wr_word0, wr_word1);
            rt_vld_next = 1'b1;
            rt_addr_next = ssb_pkg::ADDR_W'(rb_addr_reg + 1'b1);
            rb_vld_next = 1'b0;
         end
      end
      if (out_pos) begin
         q_oe_next = rt_vld_reg;
         if (rt_vld_reg) begin
            q_next = fetch(rt_addr_reg, mem[rt_addr_reg], wr_commit, wa0,
                           wa1, wr_word0, wr_word1);
            rt_vld_next = 1'b0;
         end
      end
      // a deselect only empties stage A
      // read request capture ignores the write side
      if (k_rise) begin
         rb_vld_next = ra_vld_reg;
         rb_addr_next = ra_addr_reg;
         ra_vld_next = !rd_n_s;
         ra_addr_next = addr_s;
      end
   end
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         ra_vld_reg <= 1'b0;
         rb_vld_reg <= 1'b0;
         rt_vld_reg <= 1'b0;
         ra_addr_reg <= ssb_pkg::ADDR_RESET;
         rb_addr_reg <= ssb_pkg::ADDR_RESET;
         rt_addr_reg <= ssb_pkg::ADDR_RESET;
         q_out <= ssb_pkg::Q_RESET;
         q_oe_out <= 1'b0;
      end else begin
         ra_vld_reg <= ra_vld_next;
         rb_vld_reg <= rb_vld_next;
         rt_vld_reg <= rt_vld_next;
         ra_addr_reg <= ra_addr_next;
         rb_addr_reg <= rb_addr_next;
         rt_addr_reg <= rt_addr_next;
         q_out <= q_next;
         q_oe_out <= q_oe_next;
      end
   end
   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rstn_in);
   sequence s_rd_take;
      k_rise && !rd_n_s;
   endsequence
   sequence s_beat0_slot;
      out_neg && rb_vld_reg && !out_pos;
   endsequence
   chk_read_capture: assert property (s_rd_take |=> ra_vld_reg)
      else $error("read request not captured");
   chk_write_capture: assert property (
      k_rise && !wr_n_s && wr_state_reg == ssb_pkg::SSB_WR_IDLE
      |=> wr_state_reg == ssb_pkg::SSB_WR_ADDR && wd0_reg == $past(data_s))
      else $error("write beat 0 not captured");
   chk_both_ports: assert property (
      s_rd_take ##0 (!wr_n_s && wr_state_reg == ssb_pkg::SSB_WR_IDLE)
      |=> ra_vld_reg && wr_state_reg == ssb_pkg::SSB_WR_ADDR)
      else $error("read and write did not start together");
   chk_pipe_step: assert property (
      !k_rise && !out_neg |=> ra_vld_reg == $past(ra_vld_reg))
      else $error("read stage moved without master rise");
   chk_beat0_drive: assert property (s_beat0_slot |=> q_oe_out)
      else $error("beat 0 not driven");
   chk_burst_next: assert property (
      s_beat0_slot ##0 !wr_commit |=> rt_vld_reg && q_out ==
      mem[$past(rb_addr_reg)] && rt_addr_reg == $past(rb_addr_reg) + 1'b1)
      else $error("burst beat 1 address wrong");
   chk_wr_on_kn: assert property (
      wr_state_reg == ssb_pkg::SSB_WR_ADDR && kn_rise |=>
      mem[$past(addr_s)] == $past(wr_word0))
      else $error("write address not taken on negative rise");
   chk_lane_abort: assert property (
      wr_commit && &lane_s |=> mem[$past(wa1)] == $past(mem[wa1]))
      else $error("aborted beat changed data");
   chk_nop_hiz: assert property (
      out_neg && !rb_vld_reg && !out_pos |=> !q_oe_out)
      else $error("idle slot driven");
   chk_stop_hold: assert property (
      !out_neg && !out_pos |=> $stable(q_out) && $stable(q_oe_out))
      else $error("outputs moved with clocks stopped");
   chk_coherent: assert property (
      s_beat0_slot ##0 (wr_commit && rb_addr_reg == wa0 && wa0 != wa1)
      |=> q_out == $past(wr_word0))
      else $error("read missed newest write data");
   chk_tied_clock: assert property (
      c_tied && kn_rise && rb_vld_reg |=> q_oe_out && rt_vld_reg)
      else $error("single clock mode not followed");
   chk_nop_keeps: assert property (
      rb_vld_reg && !out_neg |=> rb_vld_reg)
      else $error("pending read was dropped");
endmodule : ssb_sram
`default_nettype wire

/* File: sim/ssb_ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Controller model on the link side
// ==========================================
module ssb_ctrl_model (
   input wire logic clock_in,
   input wire logic [ssb_pkg::DATA_W-1:0] q_in,
   input wire logic q_oe_in,
   output logic k_out,
   output logic k_n_out,
   output logic c_out,
   output logic c_n_out,
   output logic rd_sel_n_out,
   output logic wr_sel_n_out,
   output logic [3:0] lane_n_out,
   output logic [ssb_pkg::ADDR_W-1:0] addr_out,
   output logic [ssb_pkg::DATA_W-1:0] data_out
);
   logic single = 1'b0;
   // Idle levels; clocks stand still until a frame starts
   initial begin
      {k_out, c_out, k_n_out, c_n_out} = 4'h3;
      {rd_sel_n_out, wr_sel_n_out, lane_n_out} = 6'h3F;
      addr_out = 19'h0_0000;
      data_out = 36'h0_0000_0000;
   end
   // Pins set two clocks ahead of the edge, sampled late in the half
   task automatic half(input logic kv, input logic [18:0] a,
      input logic [35:0] d, input logic [3:0] l,
      output logic [35:0] q, output logic oe);
      addr_out <= a;
      data_out <= d;
      lane_n_out <= l;
      repeat (2) @(posedge clock_in);
      k_out <= kv;
      k_n_out <= !kv;
      // Output pair undelayed: the bench samples well after the edge
      c_out <= kv | single;
      c_n_out <= !kv | single;
      @(posedge clock_in);
      #1;
      q = q_in;
      oe = q_oe_in;
      @(posedge clock_in);
   endtask : half
   // Unused write-side lines show inverted old values, never a kind constant
   task automatic cycle(input logic rd_n, wr_n, input logic [18:0] ra,
      wa, input logic [35:0] d0, d1, input logic [3:0] l0, l1,
      output logic [35:0] q0, q1, output logic oe0, oe1);
      // Selects active low, held over the k rise
      rd_sel_n_out <= rd_n;
      wr_sel_n_out <= wr_n;
      half(1'b1, ra, wr_n ? ~data_out : d0, wr_n ? ~lane_n_out : l0, q0, oe0);
      // Write address and second beat ride the k_n rise
      rd_sel_n_out <= !rd_n;
      wr_sel_n_out <= !wr_n;
      half(1'b0, wr_n ? ~addr_out : wa, wr_n ? ~data_out : d1,
         wr_n ? ~lane_n_out : l1, q1, oe1);
   endtask : cycle
   // Output pair tied high or back to following the master pair
   task automatic set_single(input logic s);
      single = s;
      c_out <= k_out | s;
      c_n_out <= k_n_out | s;
   endtask : set_single
endmodule : ssb_ctrl_model
`default_nettype wire

/* File: sim/tb_sync_sram_burst2_port.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_sync_sram_burst2_port;
   logic clock_in = 1'b0;
   logic rstn_in = 1'b0;
   logic k, k_n, c, c_n, rd_n, wr_n, q_oe;
   logic [3:0] ln;
   logic [18:0] addr;
   logic [35:0] data, q, b0, hq;
   logic [35:0] mem [16];
   logic [3:0] lt [8] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'h0, 4'hF, 4'hC, 4'h5};
   logic p1_rd = 1'b0;
   logic p2_rd = 1'b0;
   logic hoe;
   logic [18:0] p1_a, p2_a;
   int num_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   // ==========================================
   // Design, controller model, clock
   // ==========================================
   ssb_sram i_dut (.clock_in(clock_in), .rstn_in(rstn_in), .k_in(k),
      .k_n_in(k_n), .c_in(c), .c_n_in(c_n), .rd_sel_n_in(rd_n),
      .wr_sel_n_in(wr_n), .byte_lane0_wr_n_in(ln[0]),
      .byte_lane1_wr_n_in(ln[1]), .byte_lane2_wr_n_in(ln[2]),
      .byte_lane3_wr_n_in(ln[3]), .addr_in(addr), .data_in(data),
      .q_out(q), .q_oe_out(q_oe));
   ssb_ctrl_model i_ctrl (.clock_in(clock_in), .q_in(q), .q_oe_in(q_oe),
      .k_out(k), .k_n_out(k_n), .c_out(c), .c_n_out(c_n),
      .rd_sel_n_out(rd_n), .wr_sel_n_out(wr_n), .lane_n_out(ln),
      .addr_out(addr), .data_out(data));
   always #25 clock_in = !clock_in;
   // Hang guard, far above the expected run length
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         print_verdict();
      end
   end
   // ==========================================
   // Checking helpers
   // ==========================================
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      if (num_errors == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   // Pool addresses have distinct low nibbles, so a small array will do
   function automatic logic [35:0] merge(input logic [35:0] o, n,
      input logic [3:0] l);
      for (int i = 0; i < 4; i++) begin
         if (!l[i])
            o[9*i +: 9] = n[9*i +: 9];
      end
      return o;
   endfunction : merge
   function automatic logic [18:0] pick();
      logic [2:0] r;
      r = 3'($urandom);
      return (r == 3'h7) ? 19'h7FFFF : {16'h0, r};
   endfunction : pick
   // One link cycle with the reference stepped alongside
   task automatic op(input logic r, w, input logic [18:0] ra, wa,
      input logic [35:0] d0, d1, input logic [3:0] l0, l1);
      logic [35:0] q0, q1, e1;
      logic oe0, oe1;
      e1 = mem[4'(p2_a + 19'h1)];
      i_ctrl.cycle(r, w, ra, wa, d0, d1, l0, l1, q0, q1, oe0, oe1);
      // Enable marks exactly the slots of a pending read
      check({35'h0, oe0}, {35'h0, p2_rd});
      check({35'h0, oe1}, {35'h0, p2_rd});
      if (p2_rd) begin
         check(q0, b0);
         check(q1, e1);
      end
      // Lanes gate each beat; a write may overlap a read
      if (!w) begin
         mem[wa[3:0]] = merge(mem[wa[3:0]], d0, l0);
         mem[4'(wa + 19'h1)] = merge(mem[4'(wa + 19'h1)], d1, l1);
      end
      // Beat 0 of the previous read is fetched after this commit
      b0 = mem[p1_a[3:0]];
      p2_rd = p1_rd;
      p2_a = p1_a;
      p1_rd = !r;
      p1_a = ra;
   endtask : op
   task automatic rop();
      op(1'($urandom % 3 == 0), 1'($urandom % 3 == 0), pick(), pick(),
         36'({$urandom, $urandom}), 36'({$urandom, $urandom}),
         lt[$urandom % 8], lt[$urandom % 8]);
   endtask : rop
   // ==========================================
   // Main sequence
   // ==========================================
   initial begin
      void'($urandom(14));
      for (int i = 0; i < 16; i++)
         mem[i] = 36'h0;
      repeat (5) @(posedge clock_in);
      #1;
      check(q, 36'h0);
      check({35'h0, q_oe}, 36'h0);
      @(posedge clock_in);
      rstn_in <= 1'b1;
      repeat (4) @(posedge clock_in);
      // Fill the pool, wrapping from the top address to zero
      for (int i = 0; i < 10; i += 2)
         op(1'b1, 1'b0, 19'h0, (i == 8) ? 19'h7FFFF : 19'(i),
            36'({$urandom, $urandom}), 36'({$urandom, $urandom}), 4'h0, 4'h0);
      // Eight lane codes, read and write of one base together
      for (int i = 0; i < 8; i++)
         op(1'b0, 1'b0, 19'h2, 19'h2, 36'({$urandom, $urandom}),
            36'({$urandom, $urandom}), lt[i], lt[7 - i]);
      for (int n = 0; n < 260; n++) begin
         if (n == 200) begin
            op(1'b1, 1'b1, 19'h0, 19'h0, 36'h0, 36'h0, 4'hF, 4'hF);
            op(1'b1, 1'b1, 19'h0, 19'h0, 36'h0, 36'h0, 4'hF, 4'hF);
            i_ctrl.set_single(1'b1);
            repeat (8) @(posedge clock_in);
         end
         rop();
         // Stopped clocks leave the outputs where they were
         if ($urandom % 8 == 0) begin
            repeat (4) @(posedge clock_in);
            #1;
            hq = q;
            hoe = q_oe;
            repeat (12) @(posedge clock_in);
            #1;
            check(q, hq);
            check({35'h0, q_oe}, {35'h0, hoe});
            @(posedge clock_in);
         end
      end
      rop();
      rop();
      print_verdict();
   end
endmodule : tb_sync_sram_burst2_port
`default_nettype wire
